/* rtl/acc_pkg.sv */
// Constants shared by the calibration and frame-check back end.
// Assumes a 16-bit register space reached by word index over APB.
package acc_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] ACC_IDX_ID       = 6'h00;
   localparam logic [5:0] ACC_IDX_STATUS   = 6'h01;
   localparam logic [5:0] ACC_IDX_MODE     = 6'h02;
   localparam logic [5:0] ACC_IDX_CH0_CFG  = 6'h03;
   localparam logic [5:0] ACC_IDX_CHECKSUM = 6'h13;
   localparam int         ACC_RF_FIRST     = 2;
   localparam int         ACC_RF_LAST      = 18;
   localparam int         ACC_CH_STRIDE    = 5;
   localparam int         ACC_OFS_HI       = 1;
   localparam int         ACC_OFS_LO       = 2;
   localparam int         ACC_GAIN_HI      = 3;
   localparam int         ACC_GAIN_LO      = 4;

   // Mode register fields.
   localparam int ACC_MODE_RX_CHECK = 0;
   localparam int ACC_MODE_POLY     = 1;
   localparam int ACC_MODE_REGMAP   = 2;
   localparam int ACC_MODE_OSR_LSB  = 4;

   // Status register fields.
   localparam int ACC_ST_FRAME_ERR = 0;
   localparam int ACC_ST_MAP_CHG   = 1;
   localparam int ACC_ST_NOOP      = 2;
   localparam int ACC_ST_MAP_VALID = 3;

   // Reset values.
   localparam logic [15:0] ACC_MODE_RESET    = 16'h0040;
   localparam logic [15:0] ACC_OFS_HI_RESET  = 16'h0000;
   localparam logic [15:0] ACC_GAIN_HI_RESET = 16'h8000;
   localparam logic [15:0] ACC_ZERO_RESET    = 16'h0000;

   // Check polynomials and seed.
   localparam logic [15:0] ACC_POLY_A    = 16'h1021;
   localparam logic [15:0] ACC_POLY_B    = 16'h8005;
   localparam logic [15:0] ACC_CRC_SEED  = 16'hFFFF;

   // Oversampling codes 0..7 give 64 << code; the phase half range stops at 512.
   localparam logic [2:0]  ACC_OSR_CAP_CODE = 3'h4;
   localparam logic [9:0]  ACC_HALF_BASE    = 10'h020;
   localparam logic [15:0] ACC_OSR_BASE     = 16'h0040;

   // Register-map walk: 17 words of 16 bits.
   localparam logic [8:0] ACC_WALK_LAST = 9'h10F;

   // Gain factor fraction bits.
   localparam int ACC_GAIN_FRAC = 23;

endpackage

/* rtl/acc_crc16.sv */
// Bit-serial 16-bit check word engine with selectable polynomial.
// Assumes one data bit per enabled clock, most significant bit first.
`timescale 1ns/10ps
`default_nettype none
module acc_crc16 (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        seed_load,
   input  wire logic        bit_valid,
   input  wire logic        bit_in,
   input  wire logic        poly_sel,
   output logic [15:0]      crc
);
   import acc_pkg::*;

   logic feedback;
   assign feedback = bit_in ^ crc[15];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc <= ACC_CRC_SEED;
      end else if (seed_load) begin
         crc <= ACC_CRC_SEED;
      end else if (bit_valid) begin
         crc <= {crc[14:0], 1'b0} ^ (feedback ? (poly_sel ? ACC_POLY_B : ACC_POLY_A) : 16'h0000);
      end
   end
endmodule
`default_nettype wire

/* rtl/acc_cal_chan.sv */
// Offset and gain correction of one channel's conversion result.
// Assumes one result per valid pulse; the result is ready one cycle later.
`timescale 1ns/10ps
`default_nettype none
module acc_cal_chan #(
   parameter int WIDTH = 24
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             raw_valid,
   input  wire logic [WIDTH-1:0] raw_sample,
   input  wire logic [WIDTH-1:0] offset_coefficient,
   input  wire logic [WIDTH-1:0] gain_coefficient,
   output logic                  cal_valid,
   output logic [WIDTH-1:0]      cal_sample
);
   import acc_pkg::*;

   logic signed [WIDTH:0]       diff;
   logic signed [2*WIDTH+1:0]   product;
   logic signed [2*WIDTH+1:0]   scaled;
   logic signed [2*WIDTH+1:0]   max_val;
   logic signed [2*WIDTH+1:0]   min_val;
   logic [WIDTH-1:0]            sat;

   assign diff    = $signed({raw_sample[WIDTH-1], raw_sample})
                  - $signed({offset_coefficient[WIDTH-1], offset_coefficient});
   assign product = diff * $signed({1'b0, gain_coefficient});
   assign scaled  = product >>> ACC_GAIN_FRAC;
   assign max_val = $signed({{(WIDTH+3){1'b0}}, {(WIDTH-1){1'b1}}});
   assign min_val = -max_val - 1;

   always_comb begin
      if (scaled > max_val) begin
         sat = {1'b0, {(WIDTH-1){1'b1}}};
      end else if (scaled < min_val) begin
         sat = {1'b1, {(WIDTH-1){1'b0}}};
      end else begin
         sat = scaled[WIDTH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_valid  <= 1'b0;
         cal_sample <= '0;
      end else begin
         cal_valid <= raw_valid;
         if (raw_valid) begin
            cal_sample <= sat;
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/acc_top.sv */
// Calibration, phase limiting, frame checks and register-map checksum.
// Assumes an APB master on pclk and a frame deserialiser on pclk.
// What this block does
// - Phase range is half OVERSAMPLING_RATIO, capped 512.
// - Out-of-range phase saturates to nearer limit.
// - Phase is 10-bit signed modulator-cycle offset.
// - Data-ready timing follows programmed phase.
// - Subtract per-channel signed 24-bit offset.
// - Multiply by unsigned gain over 2^23.
// - Reset offset zero, gain 800000h.
// - Correction always applied, never disabled.
// - 16-bit check covers every frame bit.
// - Input check off at reset, bit enables.
// - Mismatch blocks commands except register write.
// - Every mismatch sets frame error flag.
// - Frame after mismatch replies as no-op.
// - Frame error clears when status shifted out.
// - Output check word always appended.
// - One bit selects the polynomial.
// - Every check starts from FFFFh.
// - Map checksum covers 02h..12h MSB first.
// - One map bit per master clock period.
// - Changed checksum sets a status flag.
// - Map flag clears on status read.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module acc_top #(
   parameter logic [15:0] ID_VALUE = 16'h5A01, // Arbitrary identification value.
   parameter int          WIDTH    = 24
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             master_clock_in,
   output logic                  sample_ready_n,
   input  wire logic             raw_valid,
   input  wire logic [WIDTH-1:0] raw_sample0,
   input  wire logic [WIDTH-1:0] raw_sample1,
   output logic                  cal_valid,
   output logic [WIDTH-1:0]      cal_sample0,
   output logic [WIDTH-1:0]      cal_sample1,
   output logic [9:0]            eff_phase0,
   output logic [9:0]            eff_phase1,
   input  wire logic             frame_start,
   input  wire logic             in_bit_valid,
   input  wire logic             in_bit,
   input  wire logic             in_check_valid,
   input  wire logic [15:0]      in_check_word,
   input  wire logic             in_cmd_is_write,
   output logic                  cmd_execute,
   output logic                  reply_noop,
   input  wire logic             out_bit_valid,
   input  wire logic             out_bit,
   output logic [15:0]           out_check_word,
   input  wire logic             status_shift_out,
   input  wire logic             status_shift_noop
);
   import acc_pkg::*;

   ////////////////////////////////////////
   // Helper functions.

   // Reset image of one writable register.
   function automatic logic [15:0] rf_reset(input int idx);
      int rel;
      rel = (idx - int'(ACC_IDX_CH0_CFG)) % ACC_CH_STRIDE;
      if (idx == int'(ACC_IDX_MODE)) begin
         rf_reset = ACC_MODE_RESET;
      end else if (idx >= int'(ACC_IDX_CH0_CFG) && idx < int'(ACC_IDX_CH0_CFG) + 2 * ACC_CH_STRIDE
                   && rel == ACC_GAIN_HI) begin
         rf_reset = ACC_GAIN_HI_RESET;
      end else if (rel == ACC_OFS_HI) begin
         rf_reset = ACC_OFS_HI_RESET;
      end else begin
         rf_reset = ACC_ZERO_RESET;
      end
   endfunction

   // Saturates a signed phase to the range allowed by the oversampling code.
   function automatic logic [9:0] phase_clamp(input logic [9:0] raw, input logic [2:0] code);
      logic signed [11:0] half;
      logic signed [11:0] val;
      logic [2:0]         cap;
      cap  = (code > ACC_OSR_CAP_CODE) ? ACC_OSR_CAP_CODE : code;
      half = $signed({2'b00, ACC_HALF_BASE << cap});
      val  = $signed({{2{raw[9]}}, raw});
      if (val > half - 12'sd1) begin
         phase_clamp = 10'(half - 12'sd1);
      end else if (val < -half) begin
         phase_clamp = 10'(-half);
      end else begin
         phase_clamp = raw;
      end
   endfunction

   // Position of a phase within one output period of the modulator count.
   function automatic logic [15:0] phase_slot(input logic [9:0] ph, input logic [15:0] oversampling_ratio);
      phase_slot = ph[9] ? 16'(oversampling_ratio + {{6{1'b1}}, ph}) : {6'h00, ph};
   endfunction

   ////////////////////////////////////////
   // Register storage and APB slave with one wait state.

   logic [15:0] regfile_reg [ACC_RF_FIRST:ACC_RF_LAST];
   logic [15:0] checksum_reg;
   logic        frame_err_reg;
   logic        map_chg_reg;
   logic        map_valid_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [5:0]  idx;
   logic        mapped;
   logic        apb_done;
   logic        status_read;
   logic [15:0] rd_data;
   logic [15:0] mode;

   assign idx         = paddr[7:2];
   assign mapped      = (idx <= ACC_IDX_CHECKSUM) && (paddr[1:0] == 2'b00);
   assign apb_done    = psel & penable & pready_reg;
   assign status_read = apb_done & ~pwrite & (idx == ACC_IDX_STATUS) & mapped;
   assign mode        = regfile_reg[ACC_RF_FIRST];
   assign pready      = pready_reg;
   assign prdata      = prdata_reg;
   assign pslverr     = pslverr_reg;

   always_comb begin
      rd_data = 16'h0000;
      if (idx == ACC_IDX_ID) begin
         rd_data = ID_VALUE;
      end else if (idx == ACC_IDX_STATUS) begin
         rd_data[ACC_ST_FRAME_ERR] = frame_err_reg;
         rd_data[ACC_ST_MAP_CHG]   = map_chg_reg;
         rd_data[ACC_ST_NOOP]      = reply_noop;
         rd_data[ACC_ST_MAP_VALID] = map_valid_reg;
      end else if (idx == ACC_IDX_CHECKSUM) begin
         rd_data = checksum_reg;
      end else if (int'(idx) >= ACC_RF_FIRST && int'(idx) <= ACC_RF_LAST) begin
         rd_data = regfile_reg[int'(idx)];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel & penable & ~pready_reg;
         if (psel & penable & ~pready_reg) begin
            prdata_reg  <= (mapped & ~pwrite) ? {16'h0000, rd_data} : 32'h0000_0000;
            pslverr_reg <= ~mapped;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = ACC_RF_FIRST; i <= ACC_RF_LAST; i++) begin
            regfile_reg[i] <= rf_reset(i);
         end
      end else if (apb_done & pwrite & mapped
                   & int'(idx) >= ACC_RF_FIRST & int'(idx) <= ACC_RF_LAST) begin
         regfile_reg[int'(idx)] <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////
   // Master clock synchroniser and edge finder.

   logic mclk_meta_reg;
   logic mclk_sync_reg;
   logic mclk_last_reg;
   logic mclk_edge;

   assign mclk_edge = mclk_sync_reg & ~mclk_last_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_meta_reg <= 1'b0;
         mclk_sync_reg <= 1'b0;
         mclk_last_reg <= 1'b0;
      end else begin
         mclk_meta_reg <= master_clock_in;
         mclk_sync_reg <= mclk_meta_reg;
         mclk_last_reg <= mclk_sync_reg;
      end
   end

   ////////////////////////////////////////
   // Per-channel correction and phase limiting.

   logic [9:0]       eff_phase [0:1];
   logic [WIDTH-1:0] cal_s [0:1];
   logic [1:0] ch_valid;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      localparam int BASE = int'(ACC_IDX_CH0_CFG) + c * ACC_CH_STRIDE;
      acc_cal_chan #(.WIDTH(WIDTH)) u_cal (
         .pclk               (pclk),
         .presetn            (presetn),
         .raw_valid          (raw_valid),
         .raw_sample         (c == 0 ? raw_sample0 : raw_sample1),
         .offset_coefficient ({regfile_reg[BASE + ACC_OFS_HI], regfile_reg[BASE + ACC_OFS_LO][15:8]}),
         .gain_coefficient   ({regfile_reg[BASE + ACC_GAIN_HI], regfile_reg[BASE + ACC_GAIN_LO][15:8]}),
         .cal_valid          (ch_valid[c]),
         .cal_sample         (cal_s[c])
      );
      assign eff_phase[c] = phase_clamp(regfile_reg[BASE][9:0], mode[ACC_MODE_OSR_LSB +: 3]);
   end

   assign cal_valid   = &ch_valid;
   assign cal_sample0 = cal_s[0];
   assign cal_sample1 = cal_s[1];
   assign eff_phase0  = eff_phase[0];
   assign eff_phase1  = eff_phase[1];

   ////////////////////////////////////////
   // Data-ready pulse at the later channel slot.

   logic [15:0] mod_cnt_reg;
   logic [15:0] osr_len;
   logic [15:0] slot0;
   logic [15:0] slot1;
   logic [15:0] ready_slot;
   logic        ready_n_reg;

   assign osr_len        = ACC_OSR_BASE << mode[ACC_MODE_OSR_LSB +: 3];
   assign slot0          = phase_slot(eff_phase[0], osr_len);
   assign slot1          = phase_slot(eff_phase[1], osr_len);
   assign ready_slot     = (slot0 > slot1) ? slot0 : slot1;
   assign sample_ready_n = ready_n_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_cnt_reg <= 16'h0000;
         ready_n_reg <= 1'b1;
      end else begin
         if (mclk_edge) begin
            mod_cnt_reg <= (mod_cnt_reg >= osr_len - 16'h0001) ? 16'h0000 : mod_cnt_reg + 16'h0001;
         end
         ready_n_reg <= ~(mclk_edge & (mod_cnt_reg == ready_slot));
      end
   end

   ////////////////////////////////////////
   // Input and output frame checks.

   logic [15:0] rx_crc;
   logic        mismatch;
   logic        exec_reg;
   logic        noop_reg;

   acc_crc16 u_rx_crc (
      .pclk      (pclk),
      .presetn   (presetn),
      .seed_load (frame_start),
      .bit_valid (in_bit_valid),
      .bit_in    (in_bit),
      .poly_sel  (mode[ACC_MODE_POLY]),
      .crc       (rx_crc)
   );

   acc_crc16 u_tx_crc (
      .pclk      (pclk),
      .presetn   (presetn),
      .seed_load (frame_start),
      .bit_valid (out_bit_valid),
      .bit_in    (out_bit),
      .poly_sel  (mode[ACC_MODE_POLY]),
      .crc       (out_check_word)
   );

   assign mismatch    = in_check_valid & mode[ACC_MODE_RX_CHECK] & (in_check_word != rx_crc);
   assign cmd_execute = exec_reg;
   assign reply_noop  = noop_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_reg <= 1'b0;
         noop_reg <= 1'b0;
      end else begin
         exec_reg <= in_check_valid & (~mismatch | in_cmd_is_write);
         if (in_check_valid) begin
            noop_reg <= mismatch;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_err_reg <= 1'b0;
      end else if (mismatch) begin
         frame_err_reg <= 1'b1;
      end else if (status_shift_out) begin
         frame_err_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////
   // Register-map checksum walk.

   logic [8:0]  walk_ptr_reg;
   logic        walk_done_reg;
   logic [15:0] map_crc;
   logic        map_en;
   logic        walk_bit;
   logic        map_changed;

   assign map_en      = mode[ACC_MODE_REGMAP];
   assign walk_bit    = regfile_reg[ACC_RF_FIRST + int'(walk_ptr_reg[8:4])][4'hF - walk_ptr_reg[3:0]];
   assign map_changed = walk_done_reg & map_valid_reg & (map_crc != checksum_reg);

   acc_crc16 u_map_crc (
      .pclk      (pclk),
      .presetn   (presetn),
      .seed_load (walk_done_reg | ~map_en),
      .bit_valid (map_en & mclk_edge & ~walk_done_reg),
      .bit_in    (walk_bit),
      .poly_sel  (mode[ACC_MODE_POLY]),
      .crc       (map_crc)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         walk_ptr_reg  <= 9'h000;
         walk_done_reg <= 1'b0;
      end else if (!map_en) begin
         walk_ptr_reg  <= 9'h000;
         walk_done_reg <= 1'b0;
      end else begin
         walk_done_reg <= 1'b0;
         if (mclk_edge & ~walk_done_reg) begin
            walk_ptr_reg <= (walk_ptr_reg == ACC_WALK_LAST) ? 9'h000 : walk_ptr_reg + 9'h001;
            walk_done_reg <= (walk_ptr_reg == ACC_WALK_LAST);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         checksum_reg  <= 16'h0000;
         map_valid_reg <= 1'b0;
      end else if (!map_en) begin
         map_valid_reg <= 1'b0;
      end else if (walk_done_reg) begin
         checksum_reg  <= map_crc;
         map_valid_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_chg_reg <= 1'b0;
      end else if (map_changed) begin
         map_chg_reg <= 1'b1;
      end else if (status_read | (status_shift_out & status_shift_noop)) begin
         map_chg_reg <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* dv/acc_monitor.sv */
// Concurrent checks on the calibration and frame-check back end.
// Assumes it is bound into acc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module acc_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        sample_ready_n,
   input wire logic        raw_valid,
   input wire logic        cal_valid,
   input wire logic        frame_start,
   input wire logic        in_check_valid,
   input wire logic        in_cmd_is_write,
   input wire logic        cmd_execute,
   input wire logic        reply_noop,
   input wire logic        out_bit_valid,
   input wire logic [15:0] out_check_word
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   sequence s_setup; psel && !penable ##1 psel && penable; endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   property p_apb_wait; s_setup |-> s_answer; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
   property p_cal_lat; raw_valid |=> cal_valid; endproperty
   a_cal_lat: assert property (p_cal_lat) else $error("result late");
   property p_cal_idle; !raw_valid |=> !cal_valid; endproperty
   a_cal_idle: assert property (p_cal_idle) else $error("stray result");
   property p_wr_run; in_check_valid && in_cmd_is_write |=> cmd_execute; endproperty
   a_wr_run: assert property (p_wr_run) else $error("write blocked");
   property p_exec_noop; in_check_valid && !in_cmd_is_write |=> cmd_execute != reply_noop;
   endproperty
   a_exec_noop: assert property (p_exec_noop) else $error("exec and noop clash");
   property p_noop_hold; !in_check_valid |=> $stable(reply_noop); endproperty
   a_noop_hold: assert property (p_noop_hold) else $error("noop moved");
   property p_out_seed; frame_start |=> out_check_word == 16'hFFFF; endproperty
   a_out_seed: assert property (p_out_seed) else $error("bad seed");
   property p_out_hold; !out_bit_valid && !frame_start |=> $stable(out_check_word); endproperty
   a_out_hold: assert property (p_out_hold) else $error("check word moved");
   property p_rdy_pulse; !sample_ready_n |=> sample_ready_n; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
endmodule
bind acc_top acc_monitor i_mon (.*);
`default_nettype wire

/* dv/acc_host.sv */
// Host-side frame source for the serial port of acc_top.
// Assumes the block samples these lines on the rising edge of pclk.
`timescale 1ns/10ps
`default_nettype none
module acc_host (
   input  wire logic   pclk,
   output logic        frame_start,
   output logic        in_bit_valid,
   output logic        in_bit,
   output logic        in_check_valid,
   output logic [15:0] in_check_word,
   output logic        in_cmd_is_write,
   output logic        out_bit_valid,
   output logic        out_bit,
   output logic        status_shift_out,
   output logic        status_shift_noop
);
   initial begin
      {frame_start, in_bit_valid, in_bit, in_check_valid, in_check_word} = '0;
      {in_cmd_is_write, out_bit_valid, out_bit, status_shift_out, status_shift_noop} = '0;
   end
   function automatic logic [15:0] crc_word(input logic [31:0] w, input logic poly);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 31; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((w[i] ^ c[15]) ? (poly ? 16'h8005 : 16'h1021) : 16'h0);
      return c;
   endfunction
   task automatic send_frame(input logic [31:0] w, input logic poly, bad, wr);
      @(posedge pclk);
      frame_start <= 1'b1;
      for (int i = 31; i >= 0; i--) begin
         @(posedge pclk);
         frame_start <= 1'b0;
         {in_bit_valid, in_bit, out_bit_valid, out_bit} <= {1'b1, w[i], 1'b1, ~w[i]};
      end
      @(posedge pclk);
      {in_bit_valid, in_bit, out_bit_valid, out_bit} <= {1'b0, ~w[0], 1'b0, w[0]};
      in_check_valid <= 1'b1;
      in_check_word <= crc_word(w, poly) ^ {15'h0, bad};
      in_cmd_is_write <= wr;
      @(posedge pclk);
      in_check_valid <= 1'b0;
      in_check_word <= ~in_check_word;
   endtask
   task automatic shift_status(input logic noop);
      @(posedge pclk);
      {status_shift_out, status_shift_noop} <= {1'b1, noop};
      @(posedge pclk);
      status_shift_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for acc_top over APB and the frame port.
// Assumes acc_pkg, acc_top, acc_monitor and acc_host are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("FAIL %0t got %h exp %h", $time, a, b); end end
module testbench;
   import acc_pkg::*;
   localparam logic [31:0] FW = 32'hA5C3_0F96;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic        mclk = 0, raw_valid = 0, er, cal_valid, rdy_n, fs, ibv, ib, icv, iwr;
   logic        cex, rnop, obv, ob, sso, ssn;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [23:0] raw0 = 0, raw1 = 0, cal0, cal1;
   logic [15:0] icw, ocw, shadow [2:18];
   logic [9:0]  ph0;
   int          errors = 0, checked = 0;
   always #50 pclk = ~pclk;
   always #400 mclk = ~mclk;
   acc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .master_clock_in(mclk), .sample_ready_n(rdy_n), .raw_valid(raw_valid),
      .raw_sample0(raw0), .raw_sample1(raw1), .cal_valid(cal_valid), .cal_sample0(cal0),
      .cal_sample1(cal1), .eff_phase0(ph0), .eff_phase1(), .frame_start(fs),
      .in_bit_valid(ibv), .in_bit(ib), .in_check_valid(icv), .in_check_word(icw),
      .in_cmd_is_write(iwr), .cmd_execute(cex), .reply_noop(rnop), .out_bit_valid(obv),
      .out_bit(ob), .out_check_word(ocw), .status_shift_out(sso), .status_shift_noop(ssn));
   acc_host i_host (.pclk(pclk), .frame_start(fs), .in_bit_valid(ibv), .in_bit(ib),
      .in_check_valid(icv), .in_check_word(icw), .in_cmd_is_write(iwr), .out_bit_valid(obv),
      .out_bit(ob), .status_shift_out(sso), .status_shift_noop(ssn));
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, idx, 2'b00, 16'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 60);
      if (pready !== 1'b1) errors++;
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (wr && idx >= 2 && idx <= 18) shadow[idx] = wd;
   endtask
   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 16'h0);
      `CHK(rd, exp)
   endtask
   task automatic coef(input int ch, input logic [23:0] o, g);
      apb(1'b1, 6'(4 + 5 * ch), o[23:8]);
      apb(1'b1, 6'(5 + 5 * ch), {o[7:0], 8'h0});
      apb(1'b1, 6'(6 + 5 * ch), g[23:8]);
      apb(1'b1, 6'(7 + 5 * ch), {g[7:0], 8'h0});
   endtask
   function automatic logic [23:0] cal(input logic [23:0] r, input int ch);
      longint v;
      v = longint'($signed(r)) - longint'($signed({shadow[4+5*ch], shadow[5+5*ch][15:8]}));
      v = (v * longint'({shadow[6+5*ch], shadow[7+5*ch][15:8]})) >>> 23;
      if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
      if (v < -64'sh800000) v = -64'sh800000;
      return v[23:0];
   endfunction
   task automatic cal_chk(input logic [23:0] r0, r1);
      @(posedge pclk);
      {raw_valid, raw0, raw1} <= {1'b1, r0, r1};
      @(posedge pclk);
      raw_valid <= 1'b0;
      @(posedge pclk);
      `CHK({cal_valid, cal0, cal1}, {1'b1, cal(r0, 0), cal(r1, 1)})
   endtask
   task automatic ph(input logic [2:0] code, input logic [9:0] p, e);
      apb(1'b1, ACC_IDX_MODE, {9'h0, code, 4'h0});
      apb(1'b1, ACC_IDX_CH0_CFG, {6'h0, p});
      @(posedge pclk);
      `CHK(ph0, e)
   endtask
   task automatic frm(input logic poly, bad, wr, ex, nop);
      i_host.send_frame(FW, poly, bad, wr);
      @(posedge pclk);
      `CHK({cex, rnop, ocw}, {ex, nop, i_host.crc_word(~FW, poly)})
   endtask
   function automatic logic [31:0] map_crc(input logic poly);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int a = 2; a <= 18; a++)
         for (int i = 15; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((shadow[a][i] ^ c[15]) ? (poly ? 16'h8005 : 16'h1021) : 16'h0);
      return {16'h0, c};
   endfunction
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      summarize();
   end
   initial begin
      foreach (shadow[a]) shadow[a] = ACC_ZERO_RESET;
      shadow[2] = ACC_MODE_RESET;
      shadow[6] = ACC_GAIN_HI_RESET;
      shadow[11] = ACC_GAIN_HI_RESET;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(6'h06, 32'h8000);
      rdc(6'h09, 32'h0);
      rdc(ACC_IDX_MODE, 32'h40);
      apb(1'b0, 6'h14, 16'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      cal_chk(24'h123456, 24'hFEDCBA);
      coef(0, 24'h000100, 24'hC00000);
      coef(1, 24'hFFFFFF, 24'hFFFFFF);
      cal_chk(24'h001000, 24'h7FFFFF);
      coef(0, 24'h000001, 24'h800000);
      cal_chk(24'h800000, 24'h000010);
      ph(3'h1, 10'h064, 10'h03F);
      ph(3'h1, 10'h39C, 10'h3C0);
      ph(3'h0, 10'h1FF, 10'h01F);
      ph(3'h6, 10'h200, 10'h200);
      ph(3'h4, 10'h1FF, 10'h1FF);
      frm(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      apb(1'b1, ACC_IDX_MODE, 16'h0041);
      frm(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      frm(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      rdc(ACC_IDX_STATUS, 32'h5);
      frm(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      apb(1'b1, ACC_IDX_MODE, 16'h0043);
      frm(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      i_host.shift_status(1'b0);
      rdc(ACC_IDX_STATUS, 32'h0);
      apb(1'b1, ACC_IDX_MODE, 16'h0044);
      repeat (6000) @(posedge pclk);
      rdc(ACC_IDX_STATUS, 32'h8);
      rdc(ACC_IDX_CHECKSUM, map_crc(1'b0));
      apb(1'b1, 6'h0D, 16'hBEEF);
      repeat (6000) @(posedge pclk);
      rdc(ACC_IDX_STATUS, 32'hA);
      rdc(ACC_IDX_STATUS, 32'h8);
      rdc(ACC_IDX_CHECKSUM, map_crc(1'b0));
      apb(1'b1, ACC_IDX_MODE, 16'h0046);
      repeat (6000) @(posedge pclk);
      rdc(ACC_IDX_CHECKSUM, map_crc(1'b1));
      i_host.shift_status(1'b1);
      rdc(ACC_IDX_STATUS, 32'h8);
      summarize();
   end
endmodule
`default_nettype wire
